// [verilog/ueb_exec.sv]
// move/bit instruction execution unit with avalon-mm control slave
`timescale 1ns/1ps
module ueb_exec
    import ueb_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic      [15:0] dm_addr_o,
    output logic      [7:0]  dm_wdata_o,
    output logic             dm_we_o,
    output logic             dm_re_o,
    input  wire logic [7:0]  dm_rdata_i,
    output logic      [15:0] pm_addr_o,
    output logic             pm_re_o,
    input  wire logic [7:0]  pm_rdata_i,
    output logic      [5:0]  io_addr_o,
    output logic      [7:0]  io_wdata_o,
    output logic             io_we_o,
    output logic             io_re_o,
    input  wire logic [7:0]  io_rdata_i,
    input  wire logic        dbg_en_i,
    output logic             dbg_break_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] be_merge(input logic [31:0] old_v);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (avs_byteenable_i[i]) begin
                r[i*8 +: 8] = avs_writedata_i[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [4:0] ptr_base(input logic [1:0] sel);
        return (sel == PTR_X) ? REG_X : (sel == PTR_Y) ? REG_Y : REG_Z;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ueb_state_t  state;
    ueb_state_t  next_state;
    logic [31:0] ir;
    logic [15:0] kword;
    logic [7:0]  flags;
    logic [7:0]  next_flags;
    logic [15:0] sp;
    logic [15:0] next_sp;
    logic [4:0]  gpr_sel;
    logic [7:0]  pm_byte;
    logic [7:0]  ra_data;
    logic        break_hit;
    logic        illegal;
    logic        rd_ack;
    logic [1:0]  dbg_sync;

    logic [15:0] next_dm_addr;
    logic [7:0]  next_dm_wdata;
    logic        next_dm_we;
    logic        next_dm_re;
    logic [15:0] next_pm_addr;
    logic        next_pm_re;
    logic [5:0]  next_io_addr;
    logic [7:0]  next_io_wdata;
    logic        next_io_we;
    logic        next_io_re;
    logic        next_break;
    logic        done;
    logic        set_illegal;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire         idle        = (state == S_IDLE);
    wire         sel_instr   = (avs_address_i == OFF_INSTR);
    wire         sel_kword   = (avs_address_i == OFF_KWORD);
    wire         sel_flags   = (avs_address_i == OFF_FLAGS);
    wire         sel_sp      = (avs_address_i == OFF_SP);
    wire         sel_gsel    = (avs_address_i == OFF_GPR_SEL);
    wire         sel_gdata   = (avs_address_i == OFF_GPR_DATA);
    wire         sel_state   = (avs_address_i == OFF_STATE);
    wire         launch      = idle && avs_write_i && sel_instr;
    wire         sw_wr       = idle && avs_write_i;
    wire [31:0]  wmerge_fl   = be_merge({24'h0, flags});
    wire [31:0]  wmerge_sp   = be_merge({16'h0, sp});
    wire [31:0]  wmerge_gs   = be_merge({27'h0, gpr_sel});
    wire [31:0]  wmerge_gd   = be_merge({24'h0, ra_data});
    wire [31:0]  wmerge_k    = be_merge({16'h0, kword});

    ueb_op_t     op;
    wire [4:0]   fld_reg     = ir[REG_LSB +: 5];
    wire [2:0]   fld_bit     = ir[BIT_LSB +: 3];
    wire [1:0]   fld_ptr     = ir[PTR_LSB +: 2];
    wire [5:0]   fld_ioq     = ir[IOQ_LSB +: 6];
    wire [7:0]   bit_mask    = 8'h01 << fld_bit;
    wire         dbg_on      = dbg_sync[1];

    assign op = ueb_op_t'(ir[OP_LSB +: 5]);

    // regfile and shifter hookup
    logic [4:0]  ra_idx;
    logic [15:0] pv;
    logic        wa_en;
    logic [4:0]  wa_idx;
    logic [7:0]  wa_data;
    logic        wp_en;
    logic [15:0] wp_data;
    logic [7:0]  sh_dout;
    logic        sh_c;
    logic        sh_z;
    logic        sh_n;
    logic        sh_v;

    assign ra_idx = idle ? gpr_sel : fld_reg;

    ueb_regfile u_regfile (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .ra_idx_i  (ra_idx),
        .ra_data_o (ra_data),
        .rp_idx_i  (ptr_base(fld_ptr)),
        .rp_data_o (pv),
        .wa_en_i   (wa_en),
        .wa_idx_i  (wa_idx),
        .wa_data_i (wa_data),
        .wp_en_i   (wp_en),
        .wp_data_i (wp_data)
    );

    ueb_shift_unit u_shift (
        .op_i   (op),
        .din_i  (ra_data),
        .cin_i  (flags[FLG_C]),
        .dout_o (sh_dout),
        .c_o    (sh_c),
        .z_o    (sh_z),
        .n_o    (sh_n),
        .v_o    (sh_v)
    );

    // ------------------------------------------------------------
    // execution sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state    = state;
        next_flags    = flags;
        next_sp       = sp;
        next_dm_addr  = dm_addr_o;
        next_dm_wdata = dm_wdata_o;
        next_dm_we    = 1'b0;
        next_dm_re    = 1'b0;
        next_pm_addr  = pm_addr_o;
        next_pm_re    = 1'b0;
        next_io_addr  = io_addr_o;
        next_io_wdata = io_wdata_o;
        next_io_we    = 1'b0;
        next_io_re    = 1'b0;
        next_break    = 1'b0;
        done          = 1'b0;
        set_illegal   = 1'b0;
        wa_en         = 1'b0;
        wa_idx        = fld_reg;
        wa_data       = sh_dout;
        wp_en         = 1'b0;
        wp_data       = pv + ONE16;
        unique case (state)
            S_IDLE: begin
                if (launch) begin
                    next_state = S_C1;
                end
                if (sw_wr && sel_flags) begin
                    next_flags = wmerge_fl[7:0];
                end
                if (sw_wr && sel_sp) begin
                    next_sp = wmerge_sp[15:0];
                end
                if (sw_wr && sel_gdata) begin
                    wa_en   = 1'b1;
                    wa_idx  = gpr_sel;
                    wa_data = wmerge_gd[7:0];
                end
            end
            S_C1: begin
                next_state   = S_C2;
                next_dm_addr = pv;
                next_dm_wdata = ra_data;
                unique case (op)
                    OP_ST_PTR: begin
                        next_dm_we = 1'b1;
                    end
                    OP_ST_INC: begin
                        next_dm_we = 1'b1;
                        wp_en      = 1'b1; // RQ1
                    end
                    OP_ST_DEC: begin
                        next_dm_we   = 1'b1;
                        next_dm_addr = pv - ONE16; // RQ2
                        wp_en        = 1'b1;
                        wp_data      = pv - ONE16;
                    end
                    OP_ST_DISP: begin
                        next_dm_we   = 1'b1;
                        next_dm_addr = pv + {10'h000, fld_ioq}; // RQ3
                    end
                    OP_ST_DIRECT: begin
                        next_dm_we   = 1'b1;
                        next_dm_addr = kword; // RQ4
                    end
                    OP_PM_R0, OP_PM_RD, OP_PM_INC: begin
                        next_pm_re   = 1'b1; // RQ5
                        next_pm_addr = pv;
                    end
                    OP_PUSH: begin
                        next_dm_we   = 1'b1; // RQ6
                        next_dm_addr = sp;
                        next_sp      = sp - ONE16;
                    end
                    OP_POP: begin
                        next_dm_re   = 1'b1; // RQ7
                        next_dm_addr = sp + ONE16;
                        next_sp      = sp + ONE16;
                    end
                    OP_IO_SET, OP_IO_CLR: begin
                        next_io_re   = 1'b1; // RQ8
                        next_io_addr = fld_ioq;
                    end
                    OP_ROL, OP_ROR, OP_LSL, OP_LSR, OP_ASR: begin
                        wa_en             = 1'b1; // RQ9 RQ10 RQ18
                        next_flags[FLG_C] = sh_c;
                        next_flags[FLG_Z] = sh_z;
                        next_flags[FLG_N] = sh_n;
                        next_flags[FLG_V] = sh_v;
                        done              = 1'b1;
                    end
                    OP_T_CAPTURE: begin
                        next_flags[FLG_T] = ra_data[fld_bit]; // RQ11
                        done              = 1'b1;
                    end
                    OP_T_RESTORE: begin
                        wa_en   = 1'b1; // RQ12
                        wa_data = flags[FLG_T] ? (ra_data | bit_mask) : (ra_data & ~bit_mask);
                        done    = 1'b1;
                    end
                    OP_FLAG_SET: begin
                        next_flags = flags | bit_mask; // RQ13 RQ14 RQ15 RQ16
                        done       = 1'b1;
                    end
                    OP_FLAG_CLR: begin
                        next_flags = flags & ~bit_mask; // RQ13 RQ14 RQ15 RQ16
                        done       = 1'b1;
                    end
                    OP_BREAK: begin
                        next_break = dbg_on; // RQ17
                        done       = 1'b1;
                    end
                    OP_NOP: begin
                        done = 1'b1;
                    end
                    default: begin
                        set_illegal = 1'b1;
                        done        = 1'b1;
                    end
                endcase
                if (done) begin
                    next_state = S_IDLE;
                end
            end
            S_C2: begin
                next_state = S_IDLE;
                done       = 1'b1;
                if (op == OP_POP) begin
                    wa_en   = 1'b1; // RQ7
                    wa_data = dm_rdata_i;
                end
                if (op == OP_IO_SET || op == OP_IO_CLR) begin
                    next_io_we    = 1'b1; // RQ8
                    next_io_wdata = (op == OP_IO_SET) ? (io_rdata_i | bit_mask)
                                                      : (io_rdata_i & ~bit_mask);
                end
                if (op == OP_PM_R0 || op == OP_PM_RD || op == OP_PM_INC) begin
                    next_state = S_C3;
                    done       = 1'b0;
                end
            end
            S_C3: begin
                next_state = S_IDLE;
                done       = 1'b1;
                wa_en      = 1'b1; // RQ5
                wa_idx     = (op == OP_PM_R0) ? REG_R0 : fld_reg;
                wa_data    = pm_byte;
                wp_en      = (op == OP_PM_INC);
            end
        endcase
    end

    // ------------------------------------------------------------
    // avalon read path
    // ------------------------------------------------------------
    wire [31:0] state_word = {29'h0, illegal, break_hit, !idle};
    wire [31:0] rd_mux = sel_instr   ? ir :
                         sel_kword   ? {16'h0, kword} :
                         sel_flags   ? {24'h0, flags} :
                         sel_sp      ? {16'h0, sp} :
                         sel_gsel    ? {27'h0, gpr_sel} :
                         sel_gdata   ? {24'h0, ra_data} :
                         sel_state   ? state_word : 32'h0000_0000;

    assign avs_waitrequest_o = (avs_read_i && !rd_ack) || (avs_write_i && sel_instr && !done);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_ack         <= 1'b0;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            rd_ack <= avs_read_i && !rd_ack;
            if (avs_read_i && !rd_ack) begin
                avs_readdata_o <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state   <= S_IDLE;
            ir      <= 32'h0000_0000;
            kword   <= 16'h0000;
            gpr_sel <= 5'h00;
            flags   <= FLAGS_RST;
            sp      <= SP_RST;
            pm_byte <= 8'h00;
        end else begin
            state <= next_state;
            flags <= next_flags;
            sp    <= next_sp;
            if (launch) begin
                ir <= avs_writedata_i;
            end
            if (sw_wr && sel_kword) begin
                kword <= wmerge_k[15:0];
            end
            if (sw_wr && sel_gsel) begin
                gpr_sel <= wmerge_gs[4:0];
            end
            if (state == S_C2) begin
                pm_byte <= pm_rdata_i;
            end
        end
    end

    // sticky status; a new event wins over a software clear
    wire clr_status = sw_wr && sel_state;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            break_hit <= 1'b0;
            illegal   <= 1'b0;
            dbg_sync  <= 2'b00;
        end else begin
            dbg_sync  <= {dbg_sync[0], dbg_en_i};
            break_hit <= next_break || (break_hit && !clr_status);
            illegal   <= set_illegal || (illegal && !clr_status);
        end
    end

    // partner strobes, data and address from flops
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dm_addr_o   <= 16'h0000;
            dm_wdata_o  <= 8'h00;
            dm_we_o     <= 1'b0;
            dm_re_o     <= 1'b0;
            pm_addr_o   <= 16'h0000;
            pm_re_o     <= 1'b0;
            io_addr_o   <= 6'h00;
            io_wdata_o  <= 8'h00;
            io_we_o     <= 1'b0;
            io_re_o     <= 1'b0;
            dbg_break_o <= 1'b0;
        end else begin
            dm_addr_o   <= next_dm_addr;
            dm_wdata_o  <= next_dm_wdata;
            dm_we_o     <= next_dm_we;
            dm_re_o     <= next_dm_re;
            pm_addr_o   <= next_pm_addr;
            pm_re_o     <= next_pm_re;
            io_addr_o   <= next_io_addr;
            io_wdata_o  <= next_io_wdata;
            io_we_o     <= next_io_we;
            io_re_o     <= next_io_re;
            dbg_break_o <= next_break;
        end
    end

endmodule

// [verilog/ueb_pkg.sv]
// constants, types and field layout of the move/bit execution unit
//
// Overview of operation
// (RQ1) post-inc store: Rr to pointer, then pointer+1; 2 cycles, no flags
// (RQ2) pre-dec store: pointer-1 first, then Rr there; 2 cycles, no flags
// (RQ3) displacement store: Rr to Y or Z plus q, pointer kept; 2 cycles
// (RQ4) direct store: Rr to constant address k; 2 cycles, no flags
// (RQ5) program load: byte at Z to R0 or Rd, optional Z+1; 3 cycles
// (RQ6) push stores Rr on the stack; 2 cycles, no flags
// (RQ7) pop loads Rd from the stack; 2 cycles, no flags
// (RQ8) io bit set/clear forces bit b of port P only; 2 cycles
// (RQ9) rotate left through carry, old bit 7 into carry; Z,C,N,V; 1 cycle
// (RQ10) rotate right through carry, old bit 0 into carry; Z,C,N,V; 1 cycle
// (RQ11) t-flag capture copies Rr bit b into T only; 1 cycle
// (RQ12) t-flag restore copies T into Rd bit b, nothing else; 1 cycle
// (RQ13) set/clear overflow flag V alone in 1 cycle
// (RQ14) set/clear half-carry flag H alone in 1 cycle
// (RQ15) set/clear signed flag S alone in 1 cycle
// (RQ16) set/clear carry and negative flags, each alone, 1 cycle
// (RQ17) break acts only for on-chip debug and changes no flags
// (RQ18) logical shifts zero fill, arithmetic right keeps bit 7; Z,C,N,V; 1 cycle
package ueb_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [4:0] OFF_INSTR    = 5'h00;
    localparam logic [4:0] OFF_KWORD    = 5'h04;
    localparam logic [4:0] OFF_FLAGS    = 5'h08;
    localparam logic [4:0] OFF_SP       = 5'h0C;
    localparam logic [4:0] OFF_GPR_SEL  = 5'h10;
    localparam logic [4:0] OFF_GPR_DATA = 5'h14;
    localparam logic [4:0] OFF_STATE    = 5'h18;

    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [15:0] SP_RST    = 16'h0000;

    // ------------------------------------------------------------
    // instruction word fields
    // ------------------------------------------------------------
    localparam int OP_LSB  = 0;
    localparam int REG_LSB = 5;
    localparam int BIT_LSB = 10;
    localparam int PTR_LSB = 13;
    localparam int IOQ_LSB = 15;

    // status flag positions
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;

    // state register bits
    localparam int ST_BUSY    = 0;
    localparam int ST_BREAK   = 1;
    localparam int ST_ILLEGAL = 2;

    localparam logic [4:0] REG_X = 5'h1A;
    localparam logic [4:0] REG_Y = 5'h1C;
    localparam logic [4:0] REG_Z = 5'h1E;
    localparam logic [4:0] REG_R0 = 5'h00;
    localparam logic [15:0] ONE16 = 16'h0001;

    typedef enum logic [1:0] {
        PTR_X = 2'h0,
        PTR_Y = 2'h1,
        PTR_Z = 2'h2
    } ueb_ptr_t;

    typedef enum logic [4:0] {
        OP_NOP       = 5'h00,
        OP_ST_PTR    = 5'h01,
        OP_ST_INC    = 5'h02,
        OP_ST_DEC    = 5'h03,
        OP_ST_DISP   = 5'h04,
        OP_ST_DIRECT = 5'h05,
        OP_PM_R0     = 5'h06,
        OP_PM_RD     = 5'h07,
        OP_PM_INC    = 5'h08,
        OP_PUSH      = 5'h09,
        OP_POP       = 5'h0A,
        OP_IO_SET    = 5'h0B,
        OP_IO_CLR    = 5'h0C,
        OP_ROL       = 5'h0D,
        OP_ROR       = 5'h0E,
        OP_LSL       = 5'h0F,
        OP_LSR       = 5'h10,
        OP_ASR       = 5'h11,
        OP_T_CAPTURE = 5'h12,
        OP_T_RESTORE = 5'h13,
        OP_FLAG_SET  = 5'h14,
        OP_FLAG_CLR  = 5'h15,
        OP_BREAK     = 5'h16
    } ueb_op_t;

    // gray order along idle -> c1 -> c2 -> c3
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_C1   = 2'b01,
        S_C2   = 2'b11,
        S_C3   = 2'b10
    } ueb_state_t;

endpackage

// [verilog/ueb_regfile.sv]
// general purpose register file with byte port and pointer-pair port
`timescale 1ns/1ps
module ueb_regfile
    import ueb_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [4:0]  ra_idx_i,
    output logic      [7:0]  ra_data_o,
    input  wire logic [4:0]  rp_idx_i,
    output logic      [15:0] rp_data_o,
    input  wire logic        wa_en_i,
    input  wire logic [4:0]  wa_idx_i,
    input  wire logic [7:0]  wa_data_i,
    input  wire logic        wp_en_i,
    input  wire logic [15:0] wp_data_i
);

    logic [7:0] gpr [32];
    logic [4:0] rp_hi;

    assign rp_hi     = rp_idx_i | 5'h01;
    assign ra_data_o = gpr[ra_idx_i];
    assign rp_data_o = {gpr[rp_hi], gpr[rp_idx_i]};

    // pointer pair write wins over a byte write to the same register
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_gpr
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    gpr[gi] <= 8'h00;
                end else if (wp_en_i && 5'(gi) == rp_idx_i) begin
                    gpr[gi] <= wp_data_i[7:0];
                end else if (wp_en_i && 5'(gi) == rp_hi) begin
                    gpr[gi] <= wp_data_i[15:8];
                end else if (wa_en_i && 5'(gi) == wa_idx_i) begin
                    gpr[gi] <= wa_data_i;
                end
            end
        end
    endgenerate

endmodule

// [verilog/ueb_shift_unit.sv]
// rotate and shift datapath with flag results
`timescale 1ns/1ps
module ueb_shift_unit
    import ueb_pkg::*;
(
    input  wire ueb_op_t    op_i,
    input  wire logic [7:0] din_i,
    input  wire logic       cin_i,
    output logic      [7:0] dout_o,
    output logic            c_o,
    output logic            z_o,
    output logic            n_o,
    output logic            v_o
);

    always_comb begin
        dout_o = din_i;
        c_o    = cin_i;
        unique case (op_i)
            OP_ROL: begin
                dout_o = {din_i[6:0], cin_i}; // RQ9
                c_o    = din_i[7];
            end
            OP_ROR: begin
                dout_o = {cin_i, din_i[7:1]}; // RQ10
                c_o    = din_i[0];
            end
            OP_LSL: begin
                dout_o = {din_i[6:0], 1'b0}; // RQ18
                c_o    = din_i[7];
            end
            OP_LSR: begin
                dout_o = {1'b0, din_i[7:1]}; // RQ18
                c_o    = din_i[0];
            end
            OP_ASR: begin
                dout_o = {din_i[7], din_i[7:1]}; // RQ18
                c_o    = din_i[0];
            end
            default: ;
        endcase
    end

    assign z_o = (dout_o == 8'h00);
    assign n_o = dout_o[7];
    assign v_o = dout_o[7] ^ c_o;

endmodule

// [verification/ueb_mem_model.sv]
// data, program and io spaces facing the unit
`timescale 1ns/1ps
module ueb_mem_model (
    input  logic        clk_i,
    input  logic [15:0] dm_addr_i,
    input  logic [7:0]  dm_wdata_i,
    input  logic        dm_we_i,
    input  logic        dm_re_i,
    output logic [7:0]  dm_rdata_o,
    input  logic [15:0] pm_addr_i,
    input  logic        pm_re_i,
    output logic [7:0]  pm_rdata_o,
    input  logic [5:0]  io_addr_i,
    input  logic [7:0]  io_wdata_i,
    input  logic        io_we_i,
    input  logic        io_re_i,
    output logic [7:0]  io_rdata_o
);
    logic [7:0] dm [0:65535];
    logic [7:0] io [0:63];
    // unselected reads show inverted data
    assign dm_rdata_o = dm_re_i ? dm[dm_addr_i] : ~dm[dm_addr_i];
    assign pm_rdata_o = {8{pm_re_i}} ~^ (pm_addr_i[7:0] ^ 8'h3C);
    assign io_rdata_o = io_re_i ? io[io_addr_i] : ~io[io_addr_i];
    initial for (int i = 0; i < 64; i++) io[i] = 8'h81;
    always @(posedge clk_i) begin
        if (dm_we_i) dm[dm_addr_i] <= dm_wdata_i;
        if (io_we_i) io[io_addr_i] <= io_wdata_i;
    end
endmodule

// [verification/ueb_exec_chk.sv]
// port assertions for the execution unit
`timescale 1ns/1ps
module ueb_exec_chk
    import ueb_pkg::*;
(
    input logic        clk_i,
    input logic        sys_rst_i,
    input logic [4:0]  avs_address_i,
    input logic        avs_write_i,
    input logic [31:0] avs_writedata_i,
    input logic        avs_waitrequest_o,
    input logic        dm_we_o,
    input logic        dm_re_o,
    input logic        pm_re_o,
    input logic        io_we_o,
    input logic        io_re_o,
    input logic        dbg_break_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic go;
    assign go = avs_write_i && avs_address_i == OFF_INSTR;
    store_time_a: assert property ($rose(avs_write_i) && go && avs_writedata_i[4:0] == OP_ST_INC
        |-> avs_waitrequest_o [*2] ##1 (dm_we_o && !avs_waitrequest_o)) else $error("store");
    rot_time_a: assert property ($rose(avs_write_i) && go && avs_writedata_i[4:0] == OP_ROL
        |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("rotate");
    pm_time_a: assert property (pm_re_o |=> !avs_waitrequest_o && !pm_re_o)
        else $error("program load");
    pop_time_a: assert property (dm_re_o |-> !avs_waitrequest_o ##1 !dm_re_o)
        else $error("pop");
    io_rmw_a: assert property (io_re_o |=> io_we_o) else $error("io write");
    io_order_a: assert property (io_we_o |-> $past(io_re_o) && !io_re_o)
        else $error("io order");
    brk_pulse_a: assert property (dbg_break_o |=> !dbg_break_o) else $error("break");
    we_pulse_a: assert property (dm_we_o |=> !dm_we_o) else $error("store pulse");
endmodule
bind ueb_exec ueb_exec_chk u_chk (.*);

// [verification/ueb_exec_test.sv]
// bench driving the execution unit over its register port
`timescale 1ns/1ps
module ueb_exec_test;
    import ueb_pkg::*;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [4:0]  avs_address_i = 5'h00;
    logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o, q;
    logic [3:0]  avs_byteenable_i = 4'hF;
    logic        dbg_en_i = 1'b1, avs_waitrequest_o, dm_we_o, dm_re_o, pm_re_o;
    logic        io_we_o, io_re_o, dbg_break_o;
    logic [15:0] dm_addr_o, pm_addr_o;
    logic [7:0]  dm_wdata_o, dm_rdata_i, pm_rdata_i, io_wdata_o, io_rdata_i;
    logic [5:0]  io_addr_o;
    int          n_errors = 0, checks = 0, cyc = 0;
    ueb_exec u_dut (.*);
    ueb_mem_model u_mem (.clk_i(clk_i), .dm_addr_i(dm_addr_o), .dm_wdata_i(dm_wdata_o),
        .dm_we_i(dm_we_o), .dm_re_i(dm_re_o), .dm_rdata_o(dm_rdata_i), .pm_addr_i(pm_addr_o),
        .pm_re_i(pm_re_o), .pm_rdata_o(pm_rdata_i), .io_addr_i(io_addr_o),
        .io_wdata_i(io_wdata_o), .io_we_i(io_we_o), .io_re_i(io_re_o), .io_rdata_o(io_rdata_i));
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(negedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        @(posedge clk_i);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic setg(input logic [4:0] r, input logic [7:0] v);
        bus(1, OFF_GPR_SEL, {27'h0, r});
        bus(1, OFF_GPR_DATA, {24'h0, v});
    endtask
    task automatic cg(input string s, input logic [4:0] r, input logic [7:0] e);
        bus(1, OFF_GPR_SEL, {27'h0, r});
        bus(0, OFF_GPR_DATA, 32'h0000_0000);
        chk(s, {24'h0, e}, q);
    endtask
    task automatic ex(ueb_op_t o, logic [4:0] r, logic [2:0] b, logic [1:0] p, logic [5:0] f);
        bus(1, OFF_INSTR, {11'h0, f, p, b, r, o});
    endtask
    task automatic t_store;
        setg(5'h1A, 8'h10);
        setg(5'h1B, 8'h00);
        setg(5'h05, 8'hA5);
        ex(OP_ST_INC, 5'h05, 3'h0, 2'h0, 6'h00);
        cg("x", 5'h1A, 8'h11);
        chk("dm", 32'h0000_00A5, {24'h0, u_mem.dm[16'h0010]});
        bus(0, OFF_FLAGS, 32'h0000_0000);
        chk("flags", 32'h0000_0000, q);
        $display("test store done");
    endtask
    task automatic t_alu;
        ex(OP_FLAG_SET, 5'h00, 3'h0, 2'h0, 6'h00);
        ex(OP_ROL, 5'h05, 3'h0, 2'h0, 6'h00);
        cg("rol", 5'h05, 8'h4B);
        ex(OP_FLAG_CLR, 5'h00, 3'h3, 2'h0, 6'h00);
        bus(0, OFF_FLAGS, 32'h0000_0000);
        chk("flags", 32'h0000_0001, q);
        setg(5'h1E, 8'h20);
        setg(5'h1F, 8'h00);
        ex(OP_PM_INC, 5'h07, 3'h0, 2'h2, 6'h00);
        cg("pm", 5'h07, 8'h1C);
        cg("z", 5'h1E, 8'h21);
        $display("test alu done");
    endtask
    task automatic t_stack_io;
        bus(1, OFF_SP, 32'h0000_0080);
        ex(OP_PUSH, 5'h05, 3'h0, 2'h0, 6'h00);
        ex(OP_POP, 5'h08, 3'h0, 2'h0, 6'h00);
        cg("pop", 5'h08, 8'h4B);
        ex(OP_IO_SET, 5'h00, 3'h3, 2'h0, 6'h05);
        ex(OP_IO_CLR, 5'h00, 3'h0, 2'h0, 6'h05);
        ex(OP_BREAK, 5'h00, 3'h0, 2'h0, 6'h00);
        chk("io", 32'h0000_0088, {24'h0, u_mem.io[5]});
        bus(0, OFF_STATE, 32'h0000_0000);
        chk("state", 32'h0000_0002, q);
        $display("test stack io done");
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_errors++;
            stop_test;
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_store;
        t_alu;
        t_stack_io;
        stop_test;
    end
endmodule
